// [gpib_status_pkg.sv]
`default_nettype none
package gpib_status_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [11:0] IDX_INT_STATUS0 = 12'hFF8;
	localparam logic [11:0] IDX_INT_STATUS1 = 12'hFF9;
	localparam logic [11:0] IDX_ADDR_STATUS = 12'hFFA;
	localparam logic [11:0] IDX_BUS_STATUS = 12'hFFB;
	localparam logic [11:0] IDX_AUX_COMMAND = 12'hFFB;
	localparam logic [11:0] IDX_ADDRESS = 12'hFFC;
	localparam logic [11:0] IDX_SERIAL_POLL = 12'hFFD;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 13;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int AUX_SET_CLEAR_BIT = 7;
	localparam int ADDR_DUAL_BIT = 7;
	localparam int ADDR_NO_LISTEN_BIT = 6;
	localparam int ADDR_NO_TALK_BIT = 5;
	localparam int POLL_SERVICE_REQUEST_BIT_ONE_BIT = 6;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] POLL_RESET = 8'h00;
	localparam logic [31:0] AUX_RESET = 32'h0000_0000;

	// ************************************************************
	// Auxiliary features and bus commands
	// ************************************************************
	localparam logic [4:0] AUX_SOFT_RESET = 5'h00;
	localparam logic [4:0] AUX_SERVICE_REQUEST_BIT_TWO = 5'h18;
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	localparam logic [7:0] CMD_UNL = 8'h3F;
	localparam logic [7:0] CMD_UNT = 8'h5F;
	localparam logic [2:0] GRP_LISTEN = 3'h1;
	localparam logic [2:0] GRP_TALK = 3'h2;
	localparam logic [2:0] GRP_SECONDARY = 3'h3;

	typedef struct packed {
		logic atn;
		logic dav;
		logic ndac;
		logic nrfd;
		logic eoi;
		logic srq;
		logic ifc;
		logic ren;
	} bus_lines_type;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} bus_command_type;

	typedef struct packed {
		logic byteIn;
		logic byteOut;
		logic endTagged;
		logic sourceError;
		logic pollByteSent;
	} link_events_type;

	typedef struct packed {
		logic remote;
		logic lockout;
		logic atn;
		logic lpas;
		logic tpas;
		logic lads;
		logic tads;
		logic ulpa;
	} addr_status_type;

endpackage
`default_nettype wire

// [gpib_talker_listener_status.sv]
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module gpib_talker_listener_status
	import gpib_status_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire bus_lines_type busLines,
	input wire bus_command_type busCommand,
	input wire link_events_type linkEvents,
	output addr_status_type addrStatus,
	output logic talkerEnabled,
	output logic listenerEnabled,
	output logic serviceRequest,
	output logic groupZeroPending,
	output logic groupOnePending
);

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic phaseValid;
	logic phaseWrite;
	logic [11:0] phaseIndex;
	logic takeRequest;
	logic [7:0] mask0;
	logic [7:0] mask1;
	logic [7:0] ownAddress;
	logic [7:0] pollByte;
	logic [31:0] auxFeature;
	logic [7:0] status0;
	logic [7:0] status1;
	logic [7:0] next_readByte;
	logic clear0;
	logic clear1;
	logic [7:0] writeByte;

	assign takeRequest = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign writeByte = hwdata[7:0];

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			phaseValid <= 1'b0;
			phaseWrite <= 1'b0;
			phaseIndex <= 12'h000;
		end
		else
		begin
			phaseValid <= takeRequest;
			phaseWrite <= hwrite;
			phaseIndex <= haddr[IDX_MSB:IDX_LSB];
		end
	end

	// Read data is latched in the address phase so the data phase has no wait
	always_comb
	begin
		next_readByte = 8'h00;
		unique case (haddr[IDX_MSB:IDX_LSB])
			IDX_INT_STATUS0: next_readByte = status0;
			IDX_INT_STATUS1: next_readByte = status1;
			IDX_ADDR_STATUS: next_readByte = addrStatus;
			IDX_BUS_STATUS: next_readByte = busLines;
			default: next_readByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			hrdata <= 32'h0000_0000;
		else if (takeRequest && !hwrite)
			hrdata <= {24'h00_0000, next_readByte};
	end

	// Reading an interrupt status register clears its flags
	assign clear0 = takeRequest && !hwrite && haddr[IDX_MSB:IDX_LSB] == IDX_INT_STATUS0;
	assign clear1 = takeRequest && !hwrite && haddr[IDX_MSB:IDX_LSB] == IDX_INT_STATUS1;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			mask0 <= MASK_RESET;
			mask1 <= MASK_RESET;
			ownAddress <= ADDR_RESET;
			pollByte <= POLL_RESET;
		end
		else if (phaseValid && phaseWrite)
		begin
			if (phaseIndex == IDX_INT_STATUS0)
				mask0 <= writeByte;
			if (phaseIndex == IDX_INT_STATUS1)
				mask1 <= writeByte;
			if (phaseIndex == IDX_ADDRESS)
				ownAddress <= writeByte;
			if (phaseIndex == IDX_SERIAL_POLL)
				pollByte <= writeByte;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			auxFeature <= AUX_RESET;
		else if (phaseValid && phaseWrite && phaseIndex == IDX_AUX_COMMAND)
			auxFeature[writeByte[4:0]] <= writeByte[AUX_SET_CLEAR_BIT];
	end

	// ************************************************************
	// Command decode
	// ************************************************************
	logic dualPrimary;
	logic softReset;
	logic cmdValid;
	logic [7:0] cmd;
	logic [2:0] cmdGroup;
	logic myListen;
	logic myTalk;
	logic knownCmd;
	logic ifcRise;
	logic srqRise;
	logic prevIfc;
	logic prevSrq;
	logic prevRemote;
	logic spollEnable;
	logic next_lads;
	logic next_tads;
	logic listenAddr, talkAddr, listenPrimary, talkPrimary, lastAddrLsb;
	logic lockoutState, remoteState;

	// Dual mode ignores the low address bit, so two adjacent addresses answer
	function automatic logic addrMatch(input logic [7:0] code, input logic [7:0] own,
		input logic dual);
		addrMatch = dual ? (code[4:1] == own[4:1]) : (code[4:0] == own[4:0]);
	endfunction

	assign dualPrimary = ownAddress[ADDR_DUAL_BIT];
	assign talkerEnabled = !ownAddress[ADDR_NO_TALK_BIT];
	assign listenerEnabled = !ownAddress[ADDR_NO_LISTEN_BIT];
	assign softReset = auxFeature[AUX_SOFT_RESET];
	assign cmdValid = busCommand.valid && busLines.atn && !softReset;
	assign cmd = busCommand.code;
	assign cmdGroup = cmd[7:5];
	assign myListen = cmdValid && cmdGroup == GRP_LISTEN && cmd != CMD_UNL
		&& listenerEnabled && addrMatch(cmd, ownAddress, dualPrimary);
	assign myTalk = cmdValid && cmdGroup == GRP_TALK && cmd != CMD_UNT
		&& talkerEnabled && addrMatch(cmd, ownAddress, dualPrimary);
	assign knownCmd = cmdGroup != 3'h0 || cmd == CMD_GTL || cmd == CMD_SDC
		|| cmd == CMD_GET || cmd == CMD_LLO || cmd == CMD_DCL
		|| cmd == CMD_SPE || cmd == CMD_SPD;
	assign ifcRise = busLines.ifc && !prevIfc;
	assign srqRise = busLines.srq && !prevSrq;
	assign serviceRequest = pollByte[POLL_SERVICE_REQUEST_BIT_ONE_BIT] || auxFeature[AUX_SERVICE_REQUEST_BIT_TWO];

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			prevIfc <= 1'b0;
			prevSrq <= 1'b0;
			prevRemote <= 1'b0;
		end
		else
		begin
			prevIfc <= busLines.ifc;
			prevSrq <= busLines.srq;
			prevRemote <= addrStatus.remote;
		end
	end

	// ************************************************************
	// Addressed state
	// ************************************************************
	always_comb
	begin
		next_lads = addrStatus.lads;
		next_tads = addrStatus.tads;
		if (cmdValid && cmd == CMD_UNL)
			next_lads = 1'b0;
		if (cmdValid && cmd == CMD_UNT)
			next_tads = 1'b0;
		if (myListen)
			next_lads = 1'b1;
		// Another talker being addressed drops this one
		if (cmdValid && cmdGroup == GRP_TALK && cmd != CMD_UNT)
			next_tads = myTalk;
		if (busLines.ifc || softReset)
		begin
			next_lads = 1'b0;
			next_tads = 1'b0;
		end
		if (!listenerEnabled)
			next_lads = 1'b0;
		if (!talkerEnabled)
			next_tads = 1'b0;
	end

	// One process per register bit group; the port is assembled here
	assign addrStatus = {remoteState, lockoutState, busLines.atn, listenPrimary, talkPrimary,
		listenAddr, talkAddr, lastAddrLsb};

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			listenAddr <= 1'b0;
			talkAddr <= 1'b0;
			listenPrimary <= 1'b0;
			talkPrimary <= 1'b0;
			lastAddrLsb <= 1'b0;
		end
		else
		begin
			listenAddr <= next_lads;
			talkAddr <= next_tads;
			// Primary addressed states last until the next primary command
			if (cmdValid && cmdGroup != GRP_SECONDARY)
			begin
				listenPrimary <= myListen;
				talkPrimary <= myTalk;
			end
			if (myListen || myTalk)
				lastAddrLsb <= cmd[0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			lockoutState <= 1'b0;
			remoteState <= 1'b0;
			spollEnable <= 1'b0;
		end
		else
		begin
			if (!busLines.ren)
				lockoutState <= 1'b0;
			else if (cmdValid && cmd == CMD_LLO)
				lockoutState <= 1'b1;
			if (!busLines.ren)
				remoteState <= 1'b0;
			else if (myListen)
				remoteState <= 1'b1;
			else if (cmdValid && cmd == CMD_GTL && listenAddr && !lockoutState)
				remoteState <= 1'b0;
			if (cmdValid && cmd == CMD_SPE)
				spollEnable <= 1'b1;
			else if ((cmdValid && cmd == CMD_SPD) || busLines.ifc)
				spollEnable <= 1'b0;
		end
	end

	// ************************************************************
	// Interrupt status flags (set wins over clear on read)
	// ************************************************************
	logic [5:0] set0;
	logic [7:0] set1;
	logic [5:0] flags0;

	assign set0 = {linkEvents.byteIn, linkEvents.byteOut, linkEvents.endTagged,
		addrStatus.tads && spollEnable && linkEvents.pollByteSent && serviceRequest,
		addrStatus.remote != prevRemote,
		next_lads != addrStatus.lads || next_tads != addrStatus.tads};
	assign set1 = {cmdValid && cmd == CMD_GET && addrStatus.lads,
		linkEvents.sourceError,
		cmdValid && !knownCmd,
		cmdValid && cmdGroup == GRP_SECONDARY && (addrStatus.lpas || addrStatus.tpas),
		cmdValid && (cmd == CMD_DCL || (cmd == CMD_SDC && addrStatus.lads)),
		myListen || myTalk,
		srqRise,
		ifcRise};

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			flags0 <= 6'h00;
			status1 <= 8'h00;
		end
		else
		begin
			flags0 <= set0 | (clear0 ? 6'h00 : flags0);
			status1 <= set1 | (clear1 ? 8'h00 : status1);
		end
	end

	assign groupOnePending = |(status1 & mask1);
	assign groupZeroPending = |(flags0 & mask0[5:0]);
	assign status0 = {groupZeroPending, groupOnePending, flags0};

	// ************************************************************
	// Checks
	// ************************************************************
	a_ifc_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
		busLines.ifc && !$past(busLines.ifc) |=> status1[0])
		else $error("IFC rise did not set flag");
	a_group_one_sum: assert property (@(posedge clk_sys) disable iff (srst)
		(set1 & mask1) != 8'h00 && !(phaseValid && phaseWrite) |=> groupOnePending)
		else $error("group one summary wrong");
	a_group_zero_sum: assert property (@(posedge clk_sys) disable iff (srst)
		(set0 & mask0[5:0]) != 6'h00 && !(phaseValid && phaseWrite) |=> status0[7])
		else $error("group zero summary wrong");
	a_listen_address: assert property (@(posedge clk_sys) disable iff (srst)
		myListen && !busLines.ifc && !softReset |=> addrStatus.lads && addrStatus.lpas)
		else $error("own listen address not taken");
	a_talk_disable: assert property (@(posedge clk_sys) disable iff (srst)
		!talkerEnabled |=> !addrStatus.tads)
		else $error("talker active while disabled");
	a_lockout_clear: assert property (@(posedge clk_sys) disable iff (srst)
		!busLines.ren |=> !addrStatus.lockout && !addrStatus.remote)
		else $error("lockout or remote kept without REN");
	a_remote_change: assert property (@(posedge clk_sys) disable iff (srst)
		$changed(addrStatus.remote) |=> status0[1])
		else $error("remote change not flagged");
	a_own_address_hit: assert property (@(posedge clk_sys) disable iff (srst)
		myTalk |=> status1[2] && addrStatus.ulpa == $past(cmd[0]))
		else $error("own talk address not flagged");
	a_unknown_cmd: assert property (@(posedge clk_sys) disable iff (srst)
		cmdValid && (cmd == 8'h0F || cmd == 8'h02) |=> status1[5])
		else $error("unknown command not flagged");
	a_srq_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(busLines.srq) |=> status1[1])
		else $error("SRQ rise did not set flag");

endmodule
`default_nettype wire

// [inst_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module inst_bus_model
	import gpib_status_pkg::*;
(
	input wire logic clk_sys,
	output var bus_lines_type busLines,
	output var bus_command_type busCommand,
	output var link_events_type linkEvents
);
	initial
	begin
		busLines = '0;
		busCommand = '0;
		linkEvents = '0;
	end

	// ************************************************************
	// Line levels; nrfd opposes ndac so both polarities get seen
	// ************************************************************
	task automatic set_lines(input logic ren, input logic ifc, input logic srq, input logic ndac);
		@(posedge clk_sys);
		busLines.ren <= ren;
		busLines.ifc <= ifc;
		busLines.srq <= srq;
		busLines.ndac <= ndac;
		busLines.nrfd <= ~ndac;
		repeat (2) @(posedge clk_sys);
	endtask

	// ************************************************************
	// Controller command under attention
	// ************************************************************
	task automatic send_cmd(input logic [7:0] code);
		@(posedge clk_sys);
		busLines.atn <= 1'b1;
		busCommand <= {1'b1, code};
		@(posedge clk_sys);
		// Released data lines must not keep the old byte
		busCommand <= {1'b0, ~code};
		busLines.atn <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic poll_sent;
		@(posedge clk_sys);
		linkEvents.pollByteSent <= 1'b1;
		@(posedge clk_sys);
		linkEvents.pollByteSent <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	import gpib_status_pkg::*;
	logic clk_sys, srst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	bus_lines_type busLines;
	bus_command_type busCommand;
	link_events_type linkEvents;
	addr_status_type addrStatus;
	logic talkerEnabled, listenerEnabled, serviceRequest, groupZeroPending, groupOnePending;
	int failures, checked;
	assign hready = hreadyout;

	gpib_talker_listener_status dut_u (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.busLines(busLines), .busCommand(busCommand), .linkEvents(linkEvents),
		.addrStatus(addrStatus), .talkerEnabled(talkerEnabled),
		.listenerEnabled(listenerEnabled), .serviceRequest(serviceRequest),
		.groupZeroPending(groupZeroPending), .groupOnePending(groupOnePending));

	inst_bus_model bus_u (.clk_sys(clk_sys), .busLines(busLines), .busCommand(busCommand),
		.linkEvents(linkEvents));

	// ************************************************************
	// Reporting
	// ************************************************************
	task automatic give_verdict;
		$display("Counts: %0d checked, %0d failures", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Sampled mid-cycle so the edge's own updates have landed
	task automatic chk_port(input string name, input logic exp);
		logic got;
		@(negedge clk_sys);
		case (name)
			"groupZeroPending": got = groupZeroPending;
			"groupOnePending": got = groupOnePending;
			"lockout": got = addrStatus.lockout;
			"serviceRequest": got = serviceRequest;
			"tads": got = addrStatus.tads;
			"talkerEnabled": got = talkerEnabled;
			"listenerEnabled": got = listenerEnabled;
			default: got = 1'bx;
		endcase
		chk(name, {7'h00, exp}, {7'h00, got});
		@(posedge clk_sys);
	endtask

	// ************************************************************
	// AHB-Lite master
	// ************************************************************
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 100)
		begin
			failures++;
			give_verdict();
		end
	endtask

	task automatic ahb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {18'h0, idx, 2'b00};
		hwrite <= wr;
		hsize <= 3'b000;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, wd};
		wait_ready();
		rd = hrdata[7:0];
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
		logic [7:0] rd;
		ahb(1'b1, idx, wd, rd);
	endtask

	task automatic rd_chk(input string name, input logic [11:0] idx, input logic [7:0] mask,
		input logic [7:0] exp);
		logic [7:0] rd;
		ahb(1'b0, idx, 8'h00, rd);
		chk(name, exp, rd & mask);
		chk("hresp", 8'h00, {7'h00, hresp});
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b000;
		hwdata = 32'h0000_0000;
		failures = 0;
		checked = 0;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd_chk("status0", IDX_INT_STATUS0, 8'hFF, 8'h00);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h00);
		rd_chk("addrStatus", IDX_ADDR_STATUS, 8'hFF, 8'h00);
		bus_u.set_lines(1'b1, 1'b0, 1'b0, 1'b1);
		rd_chk("busStatus", IDX_BUS_STATUS, 8'hFF, 8'h21);
		$display("reset and line levels done");

		wr(IDX_ADDRESS, 8'h05);
		wr(IDX_INT_STATUS1, 8'h24);
		wr(IDX_INT_STATUS0, 8'h01);
		bus_u.send_cmd(8'h25);
		chk_port("groupZeroPending", 1'b1);
		chk_port("groupOnePending", 1'b1);
		rd_chk("addrStatus", IDX_ADDR_STATUS, 8'hFF, 8'h95);
		rd_chk("status0", IDX_INT_STATUS0, 8'hFF, 8'hC3);
		chk_port("groupZeroPending", 1'b0);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h04);
		chk_port("groupOnePending", 1'b0);
		$display("listen addressing done");

		bus_u.send_cmd(CMD_LLO);
		chk_port("lockout", 1'b1);
		bus_u.send_cmd(8'h02);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h20);
		$display("lockout and unknown command done");

		wr(IDX_AUX_COMMAND, {1'b1, 2'b00, AUX_SERVICE_REQUEST_BIT_TWO});
		chk_port("serviceRequest", 1'b1);
		bus_u.send_cmd(CMD_UNL);
		bus_u.send_cmd(CMD_SPE);
		bus_u.send_cmd(8'h45);
		bus_u.poll_sent();
		rd_chk("addrStatus", IDX_ADDR_STATUS, 8'hFF, 8'hCB);
		rd_chk("status0", IDX_INT_STATUS0, 8'hFF, 8'hC5);
		wr(IDX_AUX_COMMAND, {1'b0, 2'b00, AUX_SERVICE_REQUEST_BIT_TWO});
		chk_port("serviceRequest", 1'b0);
		$display("serial poll done");

		bus_u.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h07);
		chk_port("tads", 1'b0);
		bus_u.set_lines(1'b0, 1'b0, 1'b1, 1'b0);
		rd_chk("busStatus", IDX_BUS_STATUS, 8'hFF, 8'h14);
		rd_chk("addrStatus", IDX_ADDR_STATUS, 8'hC0, 8'h00);
		rd_chk("status0", IDX_INT_STATUS0, 8'h02, 8'h02);
		$display("clear and local return done");

		wr(IDX_ADDRESS, 8'h60);
		chk_port("talkerEnabled", 1'b0);
		chk_port("listenerEnabled", 1'b0);
		wr(IDX_ADDRESS, 8'h84);
		chk_port("talkerEnabled", 1'b1);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h00);
		bus_u.send_cmd(8'h25);
		rd_chk("status1", IDX_INT_STATUS1, 8'h04, 8'h04);
		// Secondary, device clear and trigger are known commands
		bus_u.send_cmd(8'h60);
		bus_u.send_cmd(CMD_DCL);
		bus_u.send_cmd(CMD_GET);
		rd_chk("status1", IDX_INT_STATUS1, 8'hFF, 8'h98);
		$display("address control done");
		give_verdict();
	end
endmodule
`default_nettype wire
